// ==== hw/ieg_top.sv ====
// interrupt enable and flag gating with a classic wishbone register slave
// How it works
// - control register answers at both of its two addresses, one storage
// - global enable low blocks every request to the core
// - group enable passes or blocks all peripheral sources together
// - peripheral request needs group enable whatever individual enables hold
// - timer0 overflow enable gates the timer0 overflow flag
// - separate peripheral enable register at its own address
// - enable bit 6 gates the converter done interrupt
// - enable bits 3,2,1,0 gate serial, capture, timer2 match, timer1
// - enable bits 7,5,4 ignore writes and read zero
// - reset clears enables and control bits 7..1; port flag undefined
// - flags set on their condition regardless of any enable
// - peripheral flags live in a flag register mirroring enable bits
//
// Local design decision: register access over Wishbone.
`include "ieg_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ieg_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire ieg_pkg::ieg_wadr_t adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic timer0_ovf_i,
  input wire logic ext_pin_evt_i,
  input wire logic port_change_evt_i,
  input wire logic [7:0] periph_evt_i,
  output logic core_irq_o,
  output logic bus_irq_o
);
  import ieg_pkg::*;

  // reset image as a typed constant so the upper seven bits can be sliced
  localparam ieg_byte_t CTRL_RST = `IEG_CTRL_RST;

  ieg_byte_t ctrl_r;
  ieg_byte_t ena_r;
  ieg_byte_t flag_r;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  ieg_bus_st_t st_r;
  logic [7:0] idx;
  logic acc;
  logic wr;
  logic rd;
  logic hit_ctrl;
  logic hit_ena;
  logic hit_flag;
  logic hit_stat;
  logic hit_mask;
  logic core_term;
  logic periph_term;
  logic irq_nxt;
  logic req_rise;
  logic req_d_r;
  ieg_byte_t rdata;
  ieg_byte_t ev_core;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: upper address bits must be zero for a hit
  assign idx = adr_i[7:0];
  assign acc = cyc_i && stb_i && (st_r == IEG_IDLE);
  assign wr = acc && we_i && sel_i[0];
  assign rd = acc && !we_i;
  assign hit_ctrl = (adr_i[29:8] == 22'h0) &&
    (idx == `IEG_CTRL_IDX_A || idx == `IEG_CTRL_IDX_B);
  assign hit_ena = (adr_i[29:8] == 22'h0) && (idx == `IEG_ENA_IDX);
  assign hit_flag = (adr_i[29:8] == 22'h0) && (idx == `IEG_FLAG_IDX);
  assign hit_stat = (adr_i[29:8] == 22'h0) && (idx == `IEG_STAT_IDX);
  assign hit_mask = (adr_i[29:8] == 22'h0) && (idx == `IEG_MASK_IDX);

  // one wait-free cycle: ack the cycle after the request, then drop it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= IEG_IDLE;
      ack_o <= 1'b0;
    end else begin
      case (st_r)
        IEG_IDLE: begin
          if (cyc_i && stb_i) begin
            st_r <= IEG_ACK;
            ack_o <= 1'b1;
          end
        end
        IEG_ACK: begin
          st_r <= IEG_IDLE;
          ack_o <= 1'b0;
        end
        default: begin
          st_r <= IEG_IDLE;
          ack_o <= 1'b0;
        end
      endcase
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    rdata = 8'h00;
    if (hit_ctrl) begin
      rdata = ctrl_r;
    end else if (hit_ena) begin
      rdata = ena_r & `IEG_PERIPH_MASK;
    end else if (hit_flag) begin
      rdata = flag_r & `IEG_PERIPH_MASK;
    end else if (hit_stat) begin
      rdata = {6'h00, stat_r};
    end else if (hit_mask) begin
      rdata = {6'h00, mask_r};
    end
  end

  // read data latched with ack, held until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (rd) begin
      dat_o <= {24'h0, rdata};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register: enables plus sticky core flags
  assign ev_core = {5'h00, timer0_ovf_i, ext_pin_evt_i, port_change_evt_i};

  // flags set on events whatever the enables; event beats a software clear.
  // one process owns the whole register so every bit has a single driver;
  // the port change flag sits outside the reset branch and powers up unknown
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r[7:1] <= CTRL_RST[7:1];
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_r[7:1] <= dat_i[7:1];
      end
      if (ev_core[`IEG_T0F_BIT]) begin
        ctrl_r[`IEG_T0F_BIT] <= 1'b1;
      end
      if (ev_core[`IEG_EXTF_BIT]) begin
        ctrl_r[`IEG_EXTF_BIT] <= 1'b1;
      end
    end
    // only writes and events move the port change flag, reset leaves it
    if (wr && hit_ctrl) begin
      ctrl_r[`IEG_PCF_BIT] <= dat_i[`IEG_PCF_BIT];
    end
    if (port_change_evt_i) begin
      ctrl_r[`IEG_PCF_BIT] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // peripheral enables; unimplemented bits never store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ena_r <= `IEG_ENA_RST;
    end else if (wr && hit_ena) begin
      ena_r <= dat_i[7:0] & `IEG_PERIPH_MASK;
    end
  end

  // peripheral flags: software write, event set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r <= `IEG_FLAG_RST;
    end else begin
      if (wr && hit_flag) begin
        flag_r <= (dat_i[7:0] | periph_evt_i) & `IEG_PERIPH_MASK;
      end else begin
        flag_r <= (flag_r | periph_evt_i) & `IEG_PERIPH_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request gating; software must clear flags before enabling
  assign core_term =
    (ctrl_r[`IEG_TIMER0_OVERFLOW_IRQ_ENABLE_BIT] && ctrl_r[`IEG_T0F_BIT]) ||
    (ctrl_r[`IEG_EXTIE_BIT] && ctrl_r[`IEG_EXTF_BIT]) ||
    (ctrl_r[`IEG_PCIE_BIT] && ctrl_r[`IEG_PCF_BIT]);
  assign periph_term = ctrl_r[`IEG_PERIPHERAL_GROUP_ENABLE_BIT] &&
    (|(ena_r & flag_r & `IEG_PERIPH_MASK));
  assign irq_nxt = ctrl_r[`IEG_GIE_BIT] && (core_term || periph_term);

  // registered request keeps the output glitch free, one cycle of latency
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_irq_o <= 1'b0;
    end else begin
      core_irq_o <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus interrupt: bit0 request rose, bit1 any event on the core or all eight peripheral inputs; read clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_d_r <= 1'b0;
    end else begin
      req_d_r <= irq_nxt;
    end
  end
  assign req_rise = irq_nxt && !req_d_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= 2'b00;
    end else begin
      if (rd && hit_stat) begin
        stat_r <= 2'b00;
      end
      if (req_rise) begin
        stat_r[0] <= 1'b1;
      end
      if (|ev_core || |periph_evt_i) begin
        stat_r[1] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= 2'b00;
    end else if (wr && hit_mask) begin
      mask_r <= dat_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_irq_o <= 1'b0;
    end else begin
      bus_irq_o <= |(stat_r & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_gie_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_r[`IEG_GIE_BIT] |=> !core_irq_o)
    else $error("request while global enable clear");
  a_group_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_r[`IEG_GIE_BIT] && !ctrl_r[`IEG_PERIPHERAL_GROUP_ENABLE_BIT] && !core_term)
    |=> !core_irq_o)
    else $error("peripheral passed without group enable");
  a_periph_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_r[`IEG_GIE_BIT] && ctrl_r[`IEG_PERIPHERAL_GROUP_ENABLE_BIT] &&
     ena_r[`IEG_ADC_BIT] && flag_r[`IEG_ADC_BIT]) |=> core_irq_o)
    else $error("converter interrupt not raised");
  a_timer0_count_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_r[`IEG_GIE_BIT] && ctrl_r[`IEG_TIMER0_OVERFLOW_IRQ_ENABLE_BIT] &&
     ctrl_r[`IEG_T0F_BIT]) |=> core_irq_o)
    else $error("timer0 interrupt not raised");
  a_timer2_count_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_r[`IEG_GIE_BIT] && ctrl_r[`IEG_PERIPHERAL_GROUP_ENABLE_BIT] &&
     ena_r[`IEG_TIMER2_COUNT_BIT] && flag_r[`IEG_TIMER2_COUNT_BIT]) |=> core_irq_o)
    else $error("timer2 match interrupt not raised");
  a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (ena_r & ~`IEG_PERIPH_MASK) == 8'h00)
    else $error("unimplemented enable bit set");
  a_flag_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    timer0_ovf_i |=> ctrl_r[`IEG_T0F_BIT])
    else $error("timer0 flag not set on event");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_r[`IEG_EXTF_BIT] && !(wr && hit_ctrl)) |=> ctrl_r[`IEG_EXTF_BIT])
    else $error("external flag cleared without a write");
  a_alias_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `IEG_CTRL_IDX_B && adr_i[29:8] == 22'h0 &&
     !timer0_ovf_i && !ext_pin_evt_i && !port_change_evt_i)
    |=> ctrl_r == $past(dat_i[7:0]))
    else $error("alias write missed control register");
  a_reset_clear: assert property (@(posedge clk_i)
    rst_i |=> (ena_r == 8'h00 && ctrl_r[7:1] == 7'h00))
    else $error("reset did not clear enables");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");


  // bus handshake: one ack per accepted request, never a spurious one
  a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && st_r == IEG_IDLE) |=> ack_o)
    else $error("request not acknowledged");
  a_ack_no_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ack_o && !(cyc_i && stb_i)) |=> !ack_o)
    else $error("ack without a request");
  a_unmap_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && !hit_ctrl && !hit_ena && !hit_flag && !hit_stat && !hit_mask)
    |=> dat_o == 32'h0)
    else $error("unmapped read returned data");

  // register storage: enables keep only implemented bits, flags take writes
  a_ena_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_ena) |=> ena_r == ($past(dat_i[7:0]) & `IEG_PERIPH_MASK))
    else $error("enable write not stored");
  a_pflag_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_flag && periph_evt_i == 8'h00)
    |=> flag_r == ($past(dat_i[7:0]) & `IEG_PERIPH_MASK))
    else $error("flag write not stored");
  a_pflag_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    periph_evt_i[`IEG_ADC_BIT] |=> flag_r[`IEG_ADC_BIT])
    else $error("converter flag not set on event");
  a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_flag && periph_evt_i[`IEG_TMR1_BIT])
    |=> flag_r[`IEG_TMR1_BIT])
    else $error("software clear beat a flag event");
  a_ext_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_pin_evt_i |=> ctrl_r[`IEG_EXTF_BIT])
    else $error("external flag not set on event");

  // request gating: nothing reaches the core without a live cause
  a_group_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctrl_r[`IEG_PERIPHERAL_GROUP_ENABLE_BIT] && !core_term) |=> !core_irq_o)
    else $error("peripheral request without group enable");
  a_irq_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    core_irq_o |-> $past(core_term || periph_term))
    else $error("core request without an enabled flag");
  a_bus_irq_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    (mask_r == 2'b00) |=> !bus_irq_o)
    else $error("bus interrupt while fully masked");

  c_core_irq: cover property (@(posedge clk_i) disable iff (rst_i)
    !core_irq_o ##1 core_irq_o);
  c_periph_irq: cover property (@(posedge clk_i) disable iff (rst_i)
    periph_term && ctrl_r[`IEG_GIE_BIT]);
  c_alias_rd: cover property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == `IEG_CTRL_IDX_B);
  c_bus_irq: cover property (@(posedge clk_i) disable iff (rst_i) bus_irq_o);
endmodule : ieg_top
`default_nettype wire

// ==== hw/ieg_defs.svh ====
// register offsets, field positions, reset values for the interrupt gating block
`ifndef IEG_DEFS_SVH
`define IEG_DEFS_SVH
// word indices (printed offsets), byte address is four times the index
`define IEG_CTRL_IDX_A 8'h0b
`define IEG_CTRL_IDX_B 8'h8b
`define IEG_FLAG_IDX 8'h0c
`define IEG_ENA_IDX 8'h8c
`define IEG_STAT_IDX 8'h10
`define IEG_MASK_IDX 8'h11
// control register fields
`define IEG_GIE_BIT 7
`define IEG_PERIPHERAL_GROUP_ENABLE_BIT 6
`define IEG_TIMER0_OVERFLOW_IRQ_ENABLE_BIT 5
`define IEG_EXTIE_BIT 4
`define IEG_PCIE_BIT 3
`define IEG_T0F_BIT 2
`define IEG_EXTF_BIT 1
`define IEG_PCF_BIT 0
// peripheral enable / flag fields
`define IEG_ADC_BIT 6
`define IEG_SSP_BIT 3
`define IEG_CCP_BIT 2
`define IEG_TIMER2_COUNT_BIT 1
`define IEG_TMR1_BIT 0
`define IEG_PERIPH_MASK 8'h4f
`define IEG_CTRL_RST 8'h00
`define IEG_ENA_RST 8'h00
`define IEG_FLAG_RST 8'h00
`define IEG_WB_STAT_W 2
`endif

// ==== hw/ieg_pkg.sv ====
// types shared by the interrupt gating block
package ieg_pkg;
  typedef logic [7:0] ieg_byte_t;
  typedef logic [29:0] ieg_wadr_t;
  typedef enum logic [1:0] {
    IEG_IDLE = 2'b01,
    IEG_ACK = 2'b10
  } ieg_bus_st_t;
endpackage : ieg_pkg

// ==== dv/ieg_evt_model.sv ====
// event source model for the timers, pin, port and peripherals
`timescale 1ns/1ps
`default_nettype none
module ieg_evt_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [10:0] req_i,
  output logic timer0_ovf_o,
  output logic ext_pin_evt_o,
  output logic port_change_evt_o,
  output logic [7:0] periph_evt_o
);
  // pulses the edge after a request, as long as the request is held; ignored bits may fire too
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {port_change_evt_o, ext_pin_evt_o, timer0_ovf_o} <= 3'h0;
      periph_evt_o <= 8'h00;
    end else begin
      {port_change_evt_o, ext_pin_evt_o, timer0_ovf_o} <= req_i[10:8];
      periph_evt_o <= req_i[7:0];
    end
  end
endmodule : ieg_evt_model
`default_nettype wire

// ==== dv/interrupt_enable_gating_tb.sv ====
// self-checking bench for the interrupt gating block
`include "ieg_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_gating_tb;
  import ieg_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  ieg_wadr_t adr = '0;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0, dat_o;
  logic ack_o, core_irq_o, bus_irq_o, t0, ex, pc;
  logic [7:0] pe;
  logic [10:0] req = 11'h000;
  int error_cnt = 0, tests_run = 0;
  ieg_byte_t d;
  int pb[5] = '{6, 3, 2, 1, 0};
  always #12.5 clk_i = ~clk_i;
  ieg_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
    .ack_o(ack_o), .timer0_ovf_i(t0), .ext_pin_evt_i(ex),
    .port_change_evt_i(pc), .periph_evt_i(pe), .core_irq_o(core_irq_o),
    .bus_irq_o(bus_irq_o));
  ieg_evt_model src (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
    .timer0_ovf_o(t0), .ext_pin_evt_o(ex), .port_change_evt_o(pc),
    .periph_evt_o(pe));
  ////////////////////////////////////////////////////////////////////////
  // single classic cycle; request held until ack is sampled high
  task automatic acc(input logic w, input logic [7:0] a,
      input logic [7:0] v);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w;
    adr <= {22'h0, a}; dat <= {24'h0, v};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    d = dat_o[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : acc
  task automatic chk(input string n, input logic [7:0] e,
      input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // event pulse, then room for flag and registered request to land
  task automatic fire(input logic [10:0] v);
    @(posedge clk_i);
    req <= v;
    @(posedge clk_i);
    req <= 11'h000;
    repeat (4) @(posedge clk_i);
  endtask : fire
  task automatic irq(input logic e);
    repeat (3) @(posedge clk_i);
    chk("core_irq", {7'h0, e}, {7'h0, core_irq_o});
  endtask : irq
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    acc(0, `IEG_CTRL_IDX_A, 8'h00);
    chk("ctrl_rst", 8'h00, d & 8'hfe);
    acc(0, `IEG_ENA_IDX, 8'h00);
    chk("ena_rst", 8'h00, d);
    acc(0, `IEG_FLAG_IDX, 8'h00);
    chk("flag_rst", 8'h00, d);
    // flags must be clear before any enable goes up
    acc(1, `IEG_CTRL_IDX_A, 8'h00);
    acc(1, `IEG_CTRL_IDX_B, 8'h38);
    acc(0, `IEG_CTRL_IDX_A, 8'h00);
    chk("ctrl_alias", 8'h38, d);
    acc(1, `IEG_ENA_IDX, 8'hff);
    acc(0, `IEG_ENA_IDX, 8'h00);
    chk("ena_unimpl", 8'h4f, d);
    acc(0, 8'h20, 8'h00);
    chk("unmapped", 8'h00, d);
    // peripheral sources one at a time, all gates on, then each gate cleared in turn
    for (int i = 0; i < 5; i++) begin
      acc(1, `IEG_CTRL_IDX_A, 8'h00);
      acc(1, `IEG_FLAG_IDX, 8'h00);
      acc(1, `IEG_ENA_IDX, 8'(1 << pb[i]));
      fire(11'(1 << pb[i]) | 11'h0b0);
      irq(1'b0);
      acc(0, `IEG_FLAG_IDX, 8'h00);
      chk("pflag", 8'(1 << pb[i]), d);
      acc(1, `IEG_CTRL_IDX_A, 8'hc0);
      irq(1'b1);
      acc(1, `IEG_CTRL_IDX_A, 8'h80);
      irq(1'b0);
      acc(1, `IEG_CTRL_IDX_A, 8'h40);
      irq(1'b0);
      acc(1, `IEG_ENA_IDX, 8'h4f & ~8'(1 << pb[i]));
      acc(1, `IEG_CTRL_IDX_A, 8'hc0);
      irq(1'b0);
    end
    acc(1, `IEG_ENA_IDX, 8'h00);
    // core sources: enable 5..3 pairs with flag 2..0
    for (int j = 0; j < 3; j++) begin
      acc(1, `IEG_CTRL_IDX_A, 8'h00);
      fire(11'(1 << (8 + j)));
      acc(0, `IEG_CTRL_IDX_A, 8'h00);
      chk("cflag", 8'(4 >> j), d);
      acc(1, `IEG_CTRL_IDX_A, 8'h80 | 8'(4 >> j) | 8'(32 >> j));
      irq(1'b1);
      repeat (10) @(posedge clk_i);
      acc(0, `IEG_CTRL_IDX_B, 8'h00);
      chk("csticky", 8'h80 | 8'(4 >> j) | 8'(32 >> j), d);
      acc(1, `IEG_CTRL_IDX_A, 8'h80 | 8'(32 >> j));
      irq(1'b0);
    end
    // bus interrupt: mask, raise, read-to-clear
    acc(1, `IEG_CTRL_IDX_A, 8'h00);
    acc(1, `IEG_MASK_IDX, 8'h02);
    acc(0, `IEG_STAT_IDX, 8'h00);
    repeat (3) @(posedge clk_i);
    chk("bus_irq_idle", 8'h00, {7'h0, bus_irq_o});
    fire(11'h001);
    chk("bus_irq_set", 8'h01, {7'h0, bus_irq_o});
    acc(0, `IEG_STAT_IDX, 8'h00);
    chk("status", 8'h02, d);
    repeat (3) @(posedge clk_i);
    chk("bus_irq_clr", 8'h00, {7'h0, bus_irq_o});
    acc(1, `IEG_MASK_IDX, 8'h00);
    fire(11'h001);
    chk("bus_irq_mask", 8'h00, {7'h0, bus_irq_o});
    stop_test();
  end
endmodule : interrupt_enable_gating_tb
`default_nettype wire
